/* File: design/pshp_pkg.sv */
// Purpose: shared constants and carriers for the slot hot-plug register bank
// Assumes: 32-bit Avalon-MM register access, byte addresses
// Notes: slot status sits in the upper half of the slot control word
package pshp_pkg;

	// register map, byte addresses
	localparam int          ADDR_W        = 12;
	localparam logic [11:0] SLOT_CAP_OFS  = 12'h054;
	localparam logic [11:0] SLOT_CTL_OFS  = 12'h058;

	// slot capabilities fields
	localparam int CAP_BUTTON_PRESENT_BIT  = 0;
	localparam int CAP_PWR_CTRL_PRESENT_BIT = 1;
	localparam int CAP_LATCH_PRESENT_BIT   = 2;
	localparam int CAP_ATTN_LED_PRESENT_BIT = 3;
	localparam int CAP_PWR_LED_PRESENT_BIT = 4;
	localparam int CAP_LOW_W               = 6;
	localparam int CAP_HP_CAPABLE_BIT      = 6;
	localparam int CAP_PLV_LSB             = 7;
	localparam int CAP_PLV_W               = 8;
	localparam int CAP_PLS_LSB             = 15;
	localparam int CAP_PLS_W               = 2;
	localparam int CAP_ILOCK_BIT           = 17;
	localparam int CAP_NO_CMD_NOTIFY_BIT   = 18;
	localparam int CAP_SLOT_NUM_LSB        = 19;
	localparam int CAP_SLOT_NUM_W          = 13;

	// slot control fields
	localparam int CTL_BUTTON_EN_BIT   = 0;
	localparam int CTL_PWR_FAULT_EN_BIT = 1;
	localparam int CTL_LATCH_EN_BIT    = 2;
	localparam int CTL_PRESENCE_EN_BIT = 3;
	localparam int CTL_CMD_DONE_EN_BIT = 4;
	localparam int CTL_MASTER_EN_BIT   = 5;
	localparam int CTL_ATTN_LSB        = 6;
	localparam int CTL_PWR_LED_LSB     = 8;
	localparam int CTL_PWR_CTRL_BIT    = 10;
	localparam int CTL_EN_W            = 6;

	// slot status fields, word bit = STS_LSB + field
	localparam int STS_LSB            = 16;
	localparam int STS_CMD_DONE_BIT   = 4;
	localparam int STS_LATCH_OPEN_BIT = 5;
	localparam int STS_PRESENT_BIT    = 6;
	localparam int STS_ILOCK_BIT      = 7;
	localparam int NUM_EVT_FLAGS      = 5;
	localparam int NUM_WAKE_EVTS      = 4;

	// reset values
	localparam logic [1:0] ATTN_LED_RST = 2'h3;
	localparam logic [1:0] PWR_LED_RST  = 2'h1;
	localparam logic       PWR_CTRL_RST = 1'h0;

	// command completion delay
	localparam int CLK_PERIOD_NS    = 50;
	localparam int CMD_DONE_NS      = 1000;
	localparam int CMD_DONE_CYCLES  = (CMD_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CMD_CNT_W        = 5;

	typedef enum logic [1:0] {
		PSHP_SCALE_X1    = 2'h0,
		PSHP_SCALE_XP1   = 2'h1,
		PSHP_SCALE_XP01  = 2'h2,
		PSHP_SCALE_XP001 = 2'h3
	} pshp_scale_t;

	typedef enum logic {
		PSHP_BUS_IDLE = 1'b0,
		PSHP_BUS_DONE = 1'b1
	} pshp_bus_st_t;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [3:0]        byteenable;
		logic [31:0]       writedata;
	} pshp_bus_req_t;

	typedef struct packed {
		logic button_press;
		logic power_fault;
		logic latch_change;
		logic presence_change;
		logic latch_open;
		logic card_present;
		logic ilock_engaged;
		logic power_off_sense;
	} pshp_slot_in_t;

	typedef struct packed {
		logic [1:0] attention_led_control;
		logic [1:0] power_led_control;
		logic       slot_power_control;
	} pshp_slot_drive_t;

	typedef struct packed {
		logic [CAP_PLV_W-1:0] power_limit_value;
		pshp_scale_t          power_limit_scale;
	} pshp_pwr_msg_t;

endpackage

/* File: design/pshp_sticky_flag.sv */
// Purpose: one write-one-to-clear event flag
// Assumes: set and clear are single-cycle synchronous strobes
// Notes: a set in the clearing cycle keeps the flag
`timescale 1ns/1ps
`default_nettype none
module pshp_sticky_flag (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	// event and clear
	input  wire logic set_evt,
	input  wire logic clr,
	// flag
	output logic      flag
);
	import pshp_pkg::*;

	typedef struct packed {
		logic flag;
	} pshp_flag_st_t;

	pshp_flag_st_t st_ff;
	pshp_flag_st_t nxt_st;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.flag = set_evt | (st_ff.flag & ~clr);
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign flag = st_ff.flag;
endmodule
`default_nettype wire

/* File: design/pshp_slot_regs.sv */
// Purpose: slot capabilities, slot control and slot status of one switch port
// Assumes: Avalon-MM slave, all inputs synchronous to core_clk
// Notes:
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pshp_slot_regs (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rstn,
	// register bus
	input  wire pshp_pkg::pshp_bus_req_t   avs_req,
	output logic [31:0]                    avs_readdata,
	output logic                           avs_waitrequest,
	// port configuration
	input  wire logic                      slot_implemented,
	input  wire logic                      cfg_load_en,
	input  wire logic                      upstream_port,
	input  wire logic                      dl_up,
	// slot hardware
	input  wire pshp_pkg::pshp_slot_in_t   slot_in,
	output pshp_pkg::pshp_slot_drive_t     slot_drive,
	// power limit message
	output logic                           pwr_msg_valid,
	output pshp_pkg::pshp_pwr_msg_t        pwr_msg,
	input  wire logic                      pwr_msg_ready,
	// hot-plug events to the port
	output logic                           hp_irq,
	output logic                           hp_wake
);
	import pshp_pkg::*;

	typedef struct packed {
		pshp_bus_st_t                bus;
		logic [31:0]                 rdata;
		logic [CAP_LOW_W-1:0]        cap_low;
		logic                        hot_plug_capable;
		logic [CAP_PLV_W-1:0]        power_limit_value;
		pshp_scale_t                 power_limit_scale;
		logic                        interlock_present;
		logic [CAP_SLOT_NUM_W-1:0]   physical_slot_number;
		logic [CTL_EN_W-1:0]         ctl_en;
		logic [1:0]                  attention_led_control;
		logic [1:0]                  power_led_control;
		logic                        slot_power_control;
		logic                        dl_up_prev;
		logic                        msg_valid;
		pshp_pwr_msg_t               msg;
		logic [CMD_CNT_W-1:0]        cmd_cnt;
		logic                        irq;
		logic                        wake;
	} pshp_st_t;

	pshp_st_t st_ff;
	pshp_st_t nxt_st;

	logic [NUM_EVT_FLAGS-1:0] evt_set;
	logic [NUM_EVT_FLAGS-1:0] evt_clr;
	logic [NUM_EVT_FLAGS-1:0] evt_flag;
	logic                     req;
	logic                     acc;
	logic                     wr_cap;
	logic                     wr_ctl;
	logic                     wr_ctl_lo;
	logic                     wr_ctl_hi;
	logic [31:0]              cap_rd;
	logic [31:0]              ctl_rd;
	logic [CAP_LOW_W-1:0]     cap_low_eff;
	logic                     hp_cap_eff;
	logic [CTL_EN_W-1:0]      en_gate;
	logic [CTL_EN_W-1:0]      en_eff;
	logic                     attn_gate;
	logic                     pled_gate;
	logic                     pctl_gate;
	logic [1:0]               attn_eff;
	logic [1:0]               pled_eff;
	logic                     pctl_eff;
	logic [CAP_PLV_W-1:0]     plv_eff;
	pshp_scale_t              pls_eff;

	// capability view, all zero without a slot
	always_comb begin
		cap_low_eff = slot_implemented ? st_ff.cap_low : '0;
		hp_cap_eff  = slot_implemented & st_ff.hot_plug_capable;
		plv_eff     = slot_implemented ? st_ff.power_limit_value : '0;
		pls_eff     = slot_implemented ? st_ff.power_limit_scale : PSHP_SCALE_X1;
		cap_rd      = '0;
		cap_rd[CAP_LOW_W-1:0]                                  = cap_low_eff;
		cap_rd[CAP_HP_CAPABLE_BIT]                             = hp_cap_eff;
		cap_rd[CAP_PLV_LSB +: CAP_PLV_W]                       = plv_eff;
		cap_rd[CAP_PLS_LSB +: CAP_PLS_W]                       = pls_eff;
		cap_rd[CAP_ILOCK_BIT]                                  = slot_implemented & st_ff.interlock_present;
		cap_rd[CAP_NO_CMD_NOTIFY_BIT]                          = 1'b0;
		cap_rd[CAP_SLOT_NUM_LSB +: CAP_SLOT_NUM_W]             =
			slot_implemented ? st_ff.physical_slot_number : '0;
	end

	// control gating by capability; presence detect enable is never gated
	always_comb begin
		en_gate                      = '0;
		en_gate[CTL_BUTTON_EN_BIT]   = cap_low_eff[CAP_BUTTON_PRESENT_BIT];
		en_gate[CTL_PWR_FAULT_EN_BIT] = cap_low_eff[CAP_PWR_CTRL_PRESENT_BIT];
		en_gate[CTL_LATCH_EN_BIT]    = cap_low_eff[CAP_LATCH_PRESENT_BIT];
		en_gate[CTL_PRESENCE_EN_BIT] = 1'b1;
		en_gate[CTL_CMD_DONE_EN_BIT] = hp_cap_eff;
		en_gate[CTL_MASTER_EN_BIT]   = hp_cap_eff;
		attn_gate = cap_low_eff[CAP_ATTN_LED_PRESENT_BIT];
		pled_gate = cap_low_eff[CAP_PWR_LED_PRESENT_BIT];
		pctl_gate = cap_low_eff[CAP_PWR_CTRL_PRESENT_BIT];
		en_eff    = st_ff.ctl_en & en_gate;
		attn_eff  = attn_gate ? st_ff.attention_led_control : 2'h0;
		pled_eff  = pled_gate ? st_ff.power_led_control : 2'h0;
		pctl_eff  = pctl_gate & st_ff.slot_power_control;
	end

	// control and status word
	always_comb begin
		ctl_rd                                 = '0;
		ctl_rd[CTL_EN_W-1:0]                   = en_eff;
		ctl_rd[CTL_ATTN_LSB +: 2]              = attn_eff;
		ctl_rd[CTL_PWR_LED_LSB +: 2]           = pled_eff;
		ctl_rd[CTL_PWR_CTRL_BIT]               = pctl_gate & slot_in.power_off_sense;
		ctl_rd[STS_LSB +: NUM_EVT_FLAGS]       = evt_flag;
		ctl_rd[STS_LSB + STS_LATCH_OPEN_BIT]   = slot_in.latch_open;
		ctl_rd[STS_LSB + STS_PRESENT_BIT]      = slot_in.card_present;
		ctl_rd[STS_LSB + STS_ILOCK_BIT]        = slot_in.ilock_engaged;
	end

	// bus decode
	always_comb begin
		req       = avs_req.read | avs_req.write;
		acc       = req & (st_ff.bus == PSHP_BUS_DONE);
		wr_cap    = acc & avs_req.write & (avs_req.address == SLOT_CAP_OFS);
		wr_ctl    = acc & avs_req.write & (avs_req.address == SLOT_CTL_OFS);
		wr_ctl_lo = wr_ctl & avs_req.byteenable[0];
		wr_ctl_hi = wr_ctl & avs_req.byteenable[1];
		evt_clr   = '0;
		if (wr_ctl & avs_req.byteenable[2]) begin
			evt_clr = avs_req.writedata[STS_LSB +: NUM_EVT_FLAGS];
		end
	end

	// event sources
	always_comb begin
		evt_set    = '0;
		evt_set[0] = slot_in.button_press;
		evt_set[1] = slot_in.power_fault;
		evt_set[2] = slot_in.latch_change;
		evt_set[3] = slot_in.presence_change;
		evt_set[STS_CMD_DONE_BIT] = (st_ff.cmd_cnt == CMD_CNT_W'(1));
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVT_FLAGS; gi = gi + 1) begin : g_flag
			pshp_sticky_flag u_flag (
				.core_clk (core_clk),
				.rstn     (rstn),
				.set_evt  (evt_set[gi]),
				.clr      (evt_clr[gi]),
				.flag     (evt_flag[gi])
			);
		end
	endgenerate

	// next state
	always_comb begin
		nxt_st = st_ff;

		// one wait cycle, then the request completes
		unique case (st_ff.bus)
			PSHP_BUS_IDLE: begin
				if (req) begin
					nxt_st.bus = PSHP_BUS_DONE;
					if (avs_req.read && avs_req.address == SLOT_CAP_OFS) begin
						nxt_st.rdata = cap_rd;
					end else if (avs_req.read && avs_req.address == SLOT_CTL_OFS) begin
						nxt_st.rdata = ctl_rd;
					end else begin
						nxt_st.rdata = '0;
					end
				end
			end
			PSHP_BUS_DONE: begin
				nxt_st.bus = PSHP_BUS_IDLE;
			end
		endcase

		// capabilities write
		if (wr_cap && slot_implemented) begin
			if (avs_req.byteenable[0] && cfg_load_en) begin
				nxt_st.cap_low = avs_req.writedata[CAP_LOW_W-1:0];
				nxt_st.hot_plug_capable = avs_req.writedata[CAP_HP_CAPABLE_BIT];
			end
			if (avs_req.byteenable[0]) begin
				nxt_st.power_limit_value[0] = avs_req.writedata[CAP_PLV_LSB];
			end
			if (avs_req.byteenable[1]) begin
				nxt_st.power_limit_value[CAP_PLV_W-1:1] = avs_req.writedata[14:8];
				nxt_st.power_limit_scale[0] = avs_req.writedata[CAP_PLS_LSB];
			end
			if (avs_req.byteenable[2]) begin
				nxt_st.power_limit_scale[1] = avs_req.writedata[CAP_PLS_LSB + 1];
				if (cfg_load_en) begin
					nxt_st.interlock_present = avs_req.writedata[CAP_ILOCK_BIT];
					nxt_st.physical_slot_number[4:0] = avs_req.writedata[23:CAP_SLOT_NUM_LSB];
				end
			end
			if (avs_req.byteenable[3] && cfg_load_en) begin
				nxt_st.physical_slot_number[CAP_SLOT_NUM_W-1:5] = avs_req.writedata[31:24];
			end
		end

		// control write, gated fields keep their value
		if (wr_ctl_lo) begin
			nxt_st.ctl_en = (avs_req.writedata[CTL_EN_W-1:0] & en_gate) | (st_ff.ctl_en & ~en_gate);
			if (attn_gate) begin
				nxt_st.attention_led_control = avs_req.writedata[CTL_ATTN_LSB +: 2];
			end
		end
		if (wr_ctl_hi) begin
			if (pled_gate && !upstream_port) begin
				nxt_st.power_led_control = avs_req.writedata[CTL_PWR_LED_LSB +: 2];
			end
			if (pctl_gate) begin
				nxt_st.slot_power_control = avs_req.writedata[CTL_PWR_CTRL_BIT];
			end
		end

		// each control write to byte 0 or 1 is a command; completion follows after a fixed delay
		if (wr_ctl_lo || wr_ctl_hi) begin
			nxt_st.cmd_cnt = CMD_CNT_W'(CMD_DONE_CYCLES);
		end else if (st_ff.cmd_cnt != '0) begin
			nxt_st.cmd_cnt = st_ff.cmd_cnt - CMD_CNT_W'(1);
		end

		// power limit message, a new trigger wins over the handshake
		nxt_st.dl_up_prev = dl_up;
		if (st_ff.msg_valid && pwr_msg_ready) begin
			nxt_st.msg_valid = 1'b0;
		end
		if (wr_cap) begin
			nxt_st.msg_valid = 1'b1;
			nxt_st.msg.power_limit_value = slot_implemented ? nxt_st.power_limit_value : '0;
			nxt_st.msg.power_limit_scale = slot_implemented ? nxt_st.power_limit_scale : PSHP_SCALE_X1;
		end else if (dl_up && !st_ff.dl_up_prev) begin
			nxt_st.msg_valid = 1'b1;
			nxt_st.msg.power_limit_value = plv_eff;
			nxt_st.msg.power_limit_scale = pls_eff;
		end

		// interrupt needs master enable; wake ignores command completion
		nxt_st.irq  = en_eff[CTL_MASTER_EN_BIT] & (|(evt_flag & en_eff[NUM_EVT_FLAGS-1:0]));
		nxt_st.wake = |(evt_flag[NUM_WAKE_EVTS-1:0] & en_eff[NUM_WAKE_EVTS-1:0]);
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			st_ff                       <= '0;
			st_ff.bus                   <= PSHP_BUS_IDLE;
			st_ff.power_limit_scale     <= PSHP_SCALE_X1;
			st_ff.msg.power_limit_scale <= PSHP_SCALE_X1;
			st_ff.attention_led_control <= ATTN_LED_RST;
			st_ff.power_led_control     <= PWR_LED_RST;
			st_ff.slot_power_control    <= PWR_CTRL_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs
	assign avs_waitrequest = req & (st_ff.bus == PSHP_BUS_IDLE);
	assign avs_readdata    = st_ff.rdata;
	assign pwr_msg_valid   = st_ff.msg_valid;
	assign pwr_msg         = st_ff.msg;
	assign hp_irq          = st_ff.irq;
	assign hp_wake         = st_ff.wake;

	always_comb begin
		slot_drive.attention_led_control = attn_eff;
		slot_drive.power_led_control     = pled_eff;
		slot_drive.slot_power_control    = pctl_eff;
	end
endmodule
`default_nettype wire

/* File: tb/pshp_slot_regs_props.sv */
// Purpose: port-level checks of the slot hot-plug register bank
// Assumes: one wait cycle per access; config levels steady around reads
// Notes: bound into every pshp_slot_regs
`timescale 1ns/1ps
`default_nettype none
module pshp_slot_regs_props (
	// clock and reset
	input wire logic                       core_clk,
	input wire logic                       rstn,
	// register bus
	input wire pshp_pkg::pshp_bus_req_t    avs_req,
	input wire logic [31:0]                avs_readdata,
	input wire logic                       avs_waitrequest,
	// configuration
	input wire logic                       slot_implemented,
	input wire logic                       upstream_port,
	input wire logic                       dl_up,
	// slot side, message and events
	input wire pshp_pkg::pshp_slot_in_t    slot_in,
	input wire pshp_pkg::pshp_slot_drive_t slot_drive,
	input wire logic                       pwr_msg_valid,
	input wire pshp_pkg::pshp_pwr_msg_t    pwr_msg,
	input wire logic                       pwr_msg_ready,
	input wire logic                       hp_irq,
	input wire logic                       hp_wake
);
	import pshp_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire logic       rd_ok  = avs_req.read & ~avs_waitrequest;
	wire logic       wr_ok  = avs_req.write & ~avs_waitrequest;
	wire logic       at_cap = avs_req.address == SLOT_CAP_OFS;
	wire logic       at_ctl = avs_req.address == SLOT_CTL_OFS;
	wire logic [9:0] wr_msg = {avs_req.writedata[14:7], avs_req.writedata[16:15]};
	wire logic       evt    = |{slot_in.button_press, slot_in.power_fault, slot_in.latch_change, slot_in.presence_change};

	one_wait_a: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait cycle");
	no_notify_a: assert property (rd_ok && at_cap |-> !avs_readdata[18])
		else $error("capability bit 18 read as one");
	slot_gate_a: assert property (rd_ok && at_cap && !slot_implemented && !$past(slot_implemented) |-> avs_readdata == 32'h0)
		else $error("capabilities not zero without slot");
	msg_write_a: assert property (wr_ok && at_cap |=> pwr_msg_valid)
		else $error("no message after capability write");
	msg_link_a: assert property ($rose(dl_up) |=> pwr_msg_valid)
		else $error("no message after link up");
	msg_hold_a: assert property (pwr_msg_valid && !pwr_msg_ready |=> pwr_msg_valid)
		else $error("message dropped before ready");
	msg_fields_a: assert property (wr_ok && at_cap && slot_implemented && avs_req.byteenable == 4'hf
		|=> pwr_msg == $past(wr_msg))
		else $error("message fields differ from written limit");
	msg_gated_a: assert property (wr_ok && at_cap && !slot_implemented |=> pwr_msg == 10'h0)
		else $error("message not zero without slot");
	attn_match_a: assert property (rd_ok && at_ctl |-> avs_readdata[7:6] == slot_drive.attention_led_control)
		else $error("attention read differs from indicator");
	upstream_a: assert property (wr_ok && at_ctl && upstream_port |=> $stable(slot_drive.power_led_control))
		else $error("upstream power indicator changed");
	wake_cause_a: assert property ($rose(hp_wake) && $past(slot_implemented, 2) == slot_implemented
		|-> $past(evt, 2) || $past(wr_ok, 2))
		else $error("wake without slot event or write");
	irq_fall_a: assert property ($fell(hp_irq) && $past(slot_implemented, 2) == slot_implemented
		|-> $past(wr_ok, 2))
		else $error("interrupt dropped without write");
endmodule
bind pshp_slot_regs pshp_slot_regs_props u_props (
	.core_clk, .rstn, .avs_req, .avs_readdata, .avs_waitrequest, .slot_implemented, .upstream_port,
	.dl_up, .slot_in, .slot_drive, .pwr_msg_valid, .pwr_msg, .pwr_msg_ready, .hp_irq, .hp_wake
);
`default_nettype wire

/* File: tb/pshp_slot_model.sv */
// Purpose: slot side: sensors, power controller and message sink
// Assumes: event requests from the bench are one-cycle strobes
// Notes: applied power trails the control by one cycle
`timescale 1ns/1ps
`default_nettype none
module pshp_slot_model (
	// clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rstn,
	// bench control
	input  wire logic [3:0]                 evt,
	input  wire logic                       slow,
	// slot hardware
	output pshp_pkg::pshp_slot_in_t         slot_in,
	input  wire pshp_pkg::pshp_slot_drive_t slot_drive,
	// message sink
	input  wire logic                       pwr_msg_valid,
	input  wire pshp_pkg::pshp_pwr_msg_t    pwr_msg,
	output logic                            pwr_msg_ready,
	output logic [7:0]                      msg_cnt,
	output pshp_pkg::pshp_pwr_msg_t         last_msg
);
	import pshp_pkg::*;
	logic [1:0] dly;
	always @(posedge core_clk) begin
		if (!rstn) begin
			slot_in <= '{card_present: 1'b1, default: 1'b0};
			pwr_msg_ready <= 1'b0;
			dly <= 2'h0;
			msg_cnt <= 8'h0;
			last_msg <= '0;
		end else begin
			slot_in.button_press <= evt[0];
			slot_in.power_fault <= evt[1];
			slot_in.latch_change <= evt[2];
			slot_in.presence_change <= evt[3];
			slot_in.latch_open <= slot_in.latch_open ^ evt[2];
			slot_in.card_present <= slot_in.card_present ^ evt[3];
			slot_in.ilock_engaged <= ~slot_in.latch_open;
			slot_in.power_off_sense <= slot_drive.slot_power_control;
			// slow sink holds a message three cycles
			dly <= (pwr_msg_valid && !pwr_msg_ready) ? dly + 2'h1 : 2'h0;
			pwr_msg_ready <= pwr_msg_valid && !pwr_msg_ready && (!slow || dly == 2'h2);
			if (pwr_msg_valid && pwr_msg_ready) begin
				msg_cnt <= msg_cnt + 8'h1;
				last_msg <= pwr_msg;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/pshp_slot_regs_test.sv */
// Purpose: self-checking bench for the slot hot-plug register bank
// Assumes: slot model on the far side, checker bound in
// Notes: random data from a fixed seed plus corner cases
`timescale 1ns/1ps
`default_nettype none
module pshp_slot_regs_test;
	import pshp_pkg::*;
	logic             core_clk = 1'b0;
	logic             rstn = 1'b0;
	pshp_bus_req_t    req = '0;
	logic             si = 1'b1, cfg = 1'b1, up = 1'b0, dl = 1'b0, slow = 1'b0;
	logic             wait_rq, mvld, mrdy, irq, wake;
	logic [3:0]       evt = 4'h0;
	logic [7:0]       cnt = 8'h0, mcnt;
	logic [31:0]      rdata, q, d, cap = 32'h0;
	logic [10:0]      ctl = 11'h1c0;
	pshp_slot_in_t    sin;
	pshp_slot_drive_t drv;
	pshp_pwr_msg_t    msg, last;
	int               n_mismatch = 0, n_tests = 0, seed = 72180;

	always #25 core_clk = ~core_clk;

	pshp_slot_regs dut (.core_clk(core_clk), .rstn(rstn), .avs_req(req), .avs_readdata(rdata),
		.avs_waitrequest(wait_rq), .slot_implemented(si), .cfg_load_en(cfg), .upstream_port(up),
		.dl_up(dl), .slot_in(sin), .slot_drive(drv), .pwr_msg_valid(mvld), .pwr_msg(msg),
		.pwr_msg_ready(mrdy), .hp_irq(irq), .hp_wake(wake));
	pshp_slot_model model (.core_clk(core_clk), .rstn(rstn), .evt(evt), .slow(slow), .slot_in(sin),
		.slot_drive(drv), .pwr_msg_valid(mvld), .pwr_msg(msg), .pwr_msg_ready(mrdy), .msg_cnt(mcnt),
		.last_msg(last));

	function automatic logic [31:0] cap_wr(logic [31:0] c, logic [31:0] w, logic l, logic s);
		logic [31:0] m;
		m = s ? (32'h0001ff80 | (l ? 32'hfffa007f : 32'h0)) : 32'h0;
		return (c & ~m) | (w & m);
	endfunction
	function automatic logic [10:0] gmask(logic [31:0] c);
		return {c[1], {2{c[4]}}, {2{c[3]}}, c[6], c[6], 1'b1, c[2], c[1], c[0]};
	endfunction

	task automatic report_and_stop;
		$display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic expire;
		n_mismatch++;
		$display("unexpected at %0t: wait ran out", $time);
		report_and_stop;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int i;
		@(posedge core_clk);
		req <= '{read: !w, write: w, address: a, byteenable: 4'hf, writedata: wd};
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (wait_rq === 1'b0)
				break;
		end
		q = rdata;
		req <= '0;
		if (i == 20)
			expire;
	endtask
	task automatic wait_msg(input logic [31:0] c);
		int i;
		for (i = 0; i < 50 && mcnt === cnt; i++)
			@(posedge core_clk);
		if (i == 50)
			expire;
		chk(last, {c[14:7], c[16:15]});
		cnt = mcnt;
	endtask
	task automatic pulse(input logic [3:0] m);
		evt <= m;
		@(posedge core_clk);
		evt <= 4'h0;
	endtask

	initial begin
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		bus(0, SLOT_CAP_OFS, 0);
		chk(q, 0);
		bus(0, SLOT_CTL_OFS, 0);
		chk(q & 32'h7ff, 0);
		chk(drv, 0);
		bus(0, 12'h000, 0);
		chk(q, 0);
		$display("reset test done");
		for (int i = 0; i < 12; i++) begin
			d = $random(seed);
			if (i < 4)
				d[16:15] = i[1:0];
			if (i == 0)
				d[31:19] = 13'h0;
			cfg <= i[0] | i[3];
			slow <= i[1];
			bus(1, SLOT_CAP_OFS, d);
			cap = cap_wr(cap, d, cfg, 1'b1);
			wait_msg(cap);
			bus(0, SLOT_CAP_OFS, 0);
			chk(q, cap);
		end
		$display("capability test done");
		cfg <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			d = $random(seed);
			up <= i[2];
			bus(1, SLOT_CAP_OFS, d);
			cap = cap_wr(cap, d, 1'b1, 1'b1);
			wait_msg(cap);
			d = $random(seed);
			bus(1, SLOT_CTL_OFS, d);
			ctl = (ctl & ~(gmask(cap) & (up ? 11'h4ff : 11'h7ff)))
				| (d[10:0] & gmask(cap) & (up ? 11'h4ff : 11'h7ff));
			bus(0, SLOT_CTL_OFS, 0);
			chk(q & 32'h7ff, ctl & gmask(cap));
			chk(drv, {ctl[7:6] & {2{cap[3]}}, ctl[9:8] & {2{cap[4]}}, ctl[10] & cap[1]});
		end
		up <= 1'b0;
		$display("control test done");
		si <= 1'b0;
		bus(0, SLOT_CAP_OFS, 0);
		chk(q, 0);
		bus(0, SLOT_CTL_OFS, 0);
		chk(q & 32'h7ff, ctl & gmask(0));
		bus(1, SLOT_CAP_OFS, 32'hffffffff);
		wait_msg(0);
		bus(1, 12'h05c, 32'hffffffff);
		si <= 1'b1;
		bus(0, SLOT_CAP_OFS, 0);
		chk(q, cap);
		$display("no-slot test done");
		bus(1, SLOT_CAP_OFS, 32'h0015a57f);
		cap = cap_wr(cap, 32'h0015a57f, 1'b1, 1'b1);
		wait_msg(cap);
		for (int i = 0; i < 4; i++) begin
			bus(1, SLOT_CTL_OFS, 32'h20 | (1 << i));
			pulse(4'h1 << i);
			bus(0, SLOT_CTL_OFS, 0);
			chk({q[16 + i], irq, wake}, 3'b111);
			bus(1, SLOT_CTL_OFS, 1 << i);
			repeat (2) @(posedge core_clk);
			chk({irq, wake}, 2'b01);
			bus(1, SLOT_CTL_OFS, 32'h1f0000 | (1 << i));
			repeat (2) @(posedge core_clk);
			chk({irq, wake}, 2'b00);
		end
		bus(1, SLOT_CTL_OFS, 32'h1f0030);
		repeat (19) @(posedge core_clk);
		chk({irq, wake}, 2'b00);
		repeat (4) @(posedge core_clk);
		chk({irq, wake}, 2'b10);
		$display("event test done");
		dl <= 1'b1;
		wait_msg(cap);
		dl <= 1'b0;
		$display("link test done");
		report_and_stop;
	end
endmodule
`default_nettype wire
